// file: include/mia_map.svh
// Register map, field positions, reset values and interrupt numbering
`ifndef MIA_MAP_SVH
`define MIA_MAP_SVH

`define MIA_ADDR_W 8
`define MIA_DATA_W 32
`define MIA_HALF_W 16

// Register byte offsets
`define MIA_OFS_FLAG_A 8'h00
`define MIA_OFS_FLAG_B 8'h04
`define MIA_OFS_ENABLE_A 8'h08
`define MIA_OFS_ENABLE_B 8'h0C
`define MIA_OFS_CRIT_A 8'h10
`define MIA_OFS_CRIT_B 8'h14
`define MIA_OFS_MODE 8'h18
`define MIA_OFS_EVT_STAT 8'h1C
`define MIA_OFS_EVT_MASK 8'h20

// Mode register bits
`define MIA_MODE_GDIS 0
`define MIA_MODE_DEBUG_EVENT_MASK 1
`define MIA_MODE_EWP 2

// Event bits
`define MIA_EVT_W 2
`define MIA_EVT_ACCEPT 0
`define MIA_EVT_RETURN 1

// Reset values
`define MIA_RST_GDIS 1'b1
`define MIA_RST_DEBUG_EVENT_MASK 1'b1
`define MIA_RST_EWP 1'b0
`define MIA_RST_WORD 32'h0000_0000
`define MIA_RST_HALF 16'h0000
`define MIA_RST_EVT 2'h0

// Maskable interrupt numbers 2..26
`define MIA_VALID_MASK 32'h07FF_FFFC
`define MIA_VEC_W 5
`define MIA_NUM_IRQ 25
// Highest priority first: bus error, then 2..23 by table, data log, os event
`define MIA_PRIO_ORDER {5'h18, 5'h02, 5'h10, 5'h03, 5'h04, 5'h05, 5'h11, 5'h06, 5'h07, 5'h08, \
  5'h12, 5'h09, 5'h0A, 5'h0B, 5'h13, 5'h0C, 5'h0D, 5'h14, 5'h15, 5'h0E, 5'h0F, 5'h16, 5'h17, 5'h19, 5'h1A}

`endif

// file: include/mia_pkg.sv
// Types for the maskable interrupt acceptance block
package mia_pkg;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_DRAIN = 3'b010,
    ST_BRANCH = 3'b100
  } mia_state_e;

  typedef struct packed {
    mia_state_e st;
    logic [31:0] flag;
    logic [31:0] enable;
    logic [31:0] crit;
    logic gdis;
    logic debug_event_mask;
    logic ewp;
    logic saved_gdis;
    logic saved_debug_event_mask;
    logic saved_ewp;
    logic [15:0] saved_status;
    logic in_isr;
    logic [4:0] vec;
    logic [1:0] evt;
    logic [1:0] evt_mask;
    logic irq;
    logic hold;
    logic flush;
    logic redirect;
    logic restore;
    logic [15:0] restore_status;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mia_state_s;

  typedef struct packed {
    logic meta;
    logic sync;
  } mia_rst_s;

endpackage : mia_pkg

// file: rtl/mia_accept.sv
// Maskable interrupt acceptance with APB register access
`timescale 1ns/1ps
`include "mia_map.svh"

module mia_accept (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire logic [31:0] IRQ_REQ,
  input wire logic RT_EMU_HALT,
  input wire logic DECODE_EMPTY,
  input wire logic RETI,
  input wire logic [15:0] CPU_STATUS,
  output logic FETCH_HOLD,
  output logic FLUSH_YOUNGER,
  output logic REDIRECT,
  output logic [4:0] REDIRECT_VECTOR,
  output logic CTX_RESTORE,
  output logic [15:0] RESTORE_STATUS,
  output logic GLOBAL_IRQ_DISABLE,
  output logic DEBUG_EVENT_MASK,
  output logic EMU_REG_WRITE_PERMIT,
  output logic IRQ
);

  mia_pkg::mia_rst_s rst;
  mia_pkg::mia_state_s cur;
  mia_pkg::mia_state_s next_s;
  logic rst_n;
  logic [31:0] eligible;
  logic found;
  logic [4:0] pick_vec;

  // Reset release through two flops
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst <= '0;
    end else begin
      rst.meta <= 1'b1;
      rst.sync <= rst.meta;
    end
  end

  assign rst_n = rst.sync;

  // Address decode shared by read and write
  function automatic logic mapped(input logic [7:0] a);
    return a == `MIA_OFS_FLAG_A || a == `MIA_OFS_FLAG_B || a == `MIA_OFS_ENABLE_A ||
      a == `MIA_OFS_ENABLE_B || a == `MIA_OFS_CRIT_A || a == `MIA_OFS_CRIT_B ||
      a == `MIA_OFS_MODE || a == `MIA_OFS_EVT_STAT || a == `MIA_OFS_EVT_MASK;
  endfunction : mapped

  // Places a 16-bit write into the low or high half of a 32-bit field
  function automatic logic [31:0] half_mask(input logic hi, input logic [15:0] d);
    return hi ? {d, `MIA_RST_HALF} : {`MIA_RST_HALF, d};
  endfunction : half_mask

  always_comb begin
    if (RT_EMU_HALT) begin
      eligible = cur.flag & cur.enable & cur.crit;
    end else if (cur.gdis) begin
      eligible = `MIA_RST_WORD;
    end else begin
      eligible = cur.flag & cur.enable;
    end
  end

  mia_prio_pick u_pick (
    .eligible(eligible),
    .found(found),
    .vector(pick_vec)
  );

  always_comb begin
    logic setup;
    logic wr;
    logic rd;
    logic [31:0] clr;
    logic [15:0] wd;
    logic [2:0] mode_rd;
    setup = PSEL & ~PENABLE;
    wr = PSEL & PENABLE & cur.pready & PWRITE;
    rd = PSEL & PENABLE & cur.pready & ~PWRITE;
    clr = `MIA_RST_WORD;
    wd = PWDATA[15:0];
    mode_rd = {cur.ewp, cur.debug_event_mask, cur.gdis};
    next_s = cur;
    next_s.flush = 1'b0;
    next_s.redirect = 1'b0;
    next_s.restore = 1'b0;

    // APB answer: ready in the first access cycle
    next_s.pready = setup;
    next_s.pslverr = setup & ~mapped(PADDR);
    if (setup) begin
      unique case (PADDR)
        `MIA_OFS_FLAG_A: next_s.prdata = {`MIA_RST_HALF, cur.flag[15:0]};
        `MIA_OFS_FLAG_B: next_s.prdata = {`MIA_RST_HALF, cur.flag[31:16]};
        `MIA_OFS_ENABLE_A: next_s.prdata = {`MIA_RST_HALF, cur.enable[15:0]};
        `MIA_OFS_ENABLE_B: next_s.prdata = {`MIA_RST_HALF, cur.enable[31:16]};
        `MIA_OFS_CRIT_A: next_s.prdata = {`MIA_RST_HALF, cur.crit[15:0]};
        `MIA_OFS_CRIT_B: next_s.prdata = {`MIA_RST_HALF, cur.crit[31:16]};
        `MIA_OFS_MODE: next_s.prdata = {29'h0000_0000, mode_rd};
        `MIA_OFS_EVT_STAT: next_s.prdata = {30'h0000_0000, cur.evt};
        `MIA_OFS_EVT_MASK: next_s.prdata = {30'h0000_0000, cur.evt_mask};
        default: next_s.prdata = `MIA_RST_WORD;
      endcase
    end

    // Register writes
    if (wr) begin
      unique case (PADDR)
        `MIA_OFS_FLAG_A: clr = half_mask(1'b0, wd);
        `MIA_OFS_FLAG_B: clr = half_mask(1'b1, wd);
        `MIA_OFS_ENABLE_A: next_s.enable[15:0] = wd;
        `MIA_OFS_ENABLE_B: next_s.enable[31:16] = wd;
        `MIA_OFS_CRIT_A: next_s.crit[15:0] = wd;
        `MIA_OFS_CRIT_B: next_s.crit[31:16] = wd;
        `MIA_OFS_MODE: begin
          next_s.gdis = PWDATA[`MIA_MODE_GDIS];
          next_s.debug_event_mask = PWDATA[`MIA_MODE_DEBUG_EVENT_MASK];
          next_s.ewp = PWDATA[`MIA_MODE_EWP];
        end
        `MIA_OFS_EVT_MASK: next_s.evt_mask = PWDATA[`MIA_EVT_W-1:0];
        default: begin
        end
      endcase
    end
    next_s.enable = next_s.enable & `MIA_VALID_MASK;
    next_s.crit = next_s.crit & `MIA_VALID_MASK;

    // Read of the event register clears it
    if (rd && PADDR == `MIA_OFS_EVT_STAT) begin
      next_s.evt = `MIA_RST_EVT;
    end

    // Acceptance sequence
    unique case (cur.st)
      mia_pkg::ST_RUN: begin
        if (found && !cur.in_isr) begin
          next_s.vec = pick_vec;
          next_s.hold = 1'b1;
          next_s.flush = 1'b1;
          next_s.st = mia_pkg::ST_DRAIN;
        end
      end
      mia_pkg::ST_DRAIN: begin
        if (DECODE_EMPTY) begin
          next_s.st = mia_pkg::ST_BRANCH;
        end
      end
      mia_pkg::ST_BRANCH: begin
        next_s.hold = 1'b0;
        next_s.st = mia_pkg::ST_RUN;
        // Flag withdrawn by software while draining: fetch resumes unredirected
        if (cur.flag[cur.vec]) begin
          next_s.redirect = 1'b1;
          clr[cur.vec] = 1'b1;
          next_s.saved_gdis = cur.gdis;
          next_s.saved_debug_event_mask = cur.debug_event_mask;
          next_s.saved_ewp = cur.ewp;
          next_s.saved_status = CPU_STATUS;
          next_s.gdis = 1'b1;
          next_s.debug_event_mask = 1'b1;
          next_s.ewp = 1'b0;
          next_s.in_isr = 1'b1;
          next_s.evt[`MIA_EVT_ACCEPT] = 1'b1;
        end
      end
    endcase

    // Return from the service routine
    if (RETI && cur.in_isr && cur.st == mia_pkg::ST_RUN) begin
      next_s.gdis = cur.saved_gdis;
      next_s.debug_event_mask = cur.saved_debug_event_mask;
      next_s.ewp = cur.saved_ewp;
      next_s.restore = 1'b1;
      next_s.restore_status = cur.saved_status;
      next_s.in_isr = 1'b0;
      next_s.evt[`MIA_EVT_RETURN] = 1'b1;
    end

    // New requests win over any clear in the same cycle
    next_s.flag = ((cur.flag & ~clr) | IRQ_REQ) & `MIA_VALID_MASK;
    next_s.irq = |(next_s.evt & next_s.evt_mask);
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
      cur.st <= mia_pkg::ST_RUN;
      cur.gdis <= `MIA_RST_GDIS;
      cur.debug_event_mask <= `MIA_RST_DEBUG_EVENT_MASK;
      cur.ewp <= `MIA_RST_EWP;
    end else begin
      cur <= next_s;
    end
  end

  assign PREADY = cur.pready;
  assign PRDATA = cur.prdata;
  assign PSLVERR = cur.pslverr;
  assign FETCH_HOLD = cur.hold;
  assign FLUSH_YOUNGER = cur.flush;
  assign REDIRECT = cur.redirect;
  assign REDIRECT_VECTOR = cur.vec;
  assign CTX_RESTORE = cur.restore;
  assign RESTORE_STATUS = cur.restore_status;
  assign GLOBAL_IRQ_DISABLE = cur.gdis;
  assign DEBUG_EVENT_MASK = cur.debug_event_mask;
  assign EMU_REG_WRITE_PERMIT = cur.ewp;
  assign IRQ = cur.irq;

endmodule : mia_accept

// file: rtl/mia_prio_pick.sv
// Fixed-priority picker over eligible maskable interrupts
`timescale 1ns/1ps
`include "mia_map.svh"

module mia_prio_pick (
  input wire logic [31:0] eligible,
  output logic found,
  output logic [4:0] vector
);

  localparam logic [`MIA_NUM_IRQ*`MIA_VEC_W-1:0] PRIO = `MIA_PRIO_ORDER;

  // Walks from lowest to highest priority so the highest one wins
  function automatic logic [5:0] pick(input logic [31:0] elig);
    logic [5:0] res;
    logic [4:0] v;
    res = 6'h00;
    for (int i = 0; i < `MIA_NUM_IRQ; i++) begin
      v = PRIO[i*`MIA_VEC_W +: `MIA_VEC_W];
      if (elig[v]) begin
        res = {1'b1, v};
      end
    end
    return res;
  endfunction : pick

  always_comb begin
    {found, vector} = pick(eligible);
  end

endmodule : mia_prio_pick

// file: testbench/mia_accept_asserts.sv
// Checker for the interrupt acceptance block
`timescale 1ns/1ps
module mia_chk (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic RT_EMU_HALT,
  input wire logic DECODE_EMPTY,
  input wire logic RETI,
  input wire logic FETCH_HOLD,
  input wire logic FLUSH_YOUNGER,
  input wire logic REDIRECT,
  input wire logic [4:0] REDIRECT_VECTOR,
  input wire logic CTX_RESTORE,
  input wire logic GLOBAL_IRQ_DISABLE,
  input wire logic DEBUG_EVENT_MASK,
  input wire logic EMU_REG_WRITE_PERMIT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  gate_open_a: assert property ($rose(FETCH_HOLD) |-> $past(!GLOBAL_IRQ_DISABLE || RT_EMU_HALT))
    else $error("accept while globally disabled");
  flush_pulse_a: assert property ($rose(FETCH_HOLD) |-> FLUSH_YOUNGER ##1 !FLUSH_YOUNGER)
    else $error("flush pulse wrong");
  drain_first_a: assert property (REDIRECT |-> $past(DECODE_EMPTY, 2))
    else $error("branch before decode drained");
  entry_mode_a: assert property (REDIRECT |-> GLOBAL_IRQ_DISABLE && DEBUG_EVENT_MASK && !EMU_REG_WRITE_PERMIT)
    else $error("entry mode bits wrong");
  hold_release_a: assert property ($rose(FETCH_HOLD) |-> ##[1:40] !FETCH_HOLD)
    else $error("fetch hold stuck");
  vector_stable_a: assert property (FETCH_HOLD && $past(FETCH_HOLD) |-> $stable(REDIRECT_VECTOR))
    else $error("vector changed during hold");
  branch_release_a: assert property (REDIRECT |-> !FETCH_HOLD && $past(FETCH_HOLD))
    else $error("redirect without hold");
  restore_cause_a: assert property (CTX_RESTORE |-> $past(RETI) ##1 !CTX_RESTORE)
    else $error("restore without return");
endmodule : mia_chk

bind mia_accept mia_chk mia_chk_inst (.CLK, .RSTN, .RT_EMU_HALT, .DECODE_EMPTY, .RETI, .FETCH_HOLD, .FLUSH_YOUNGER,
  .REDIRECT, .REDIRECT_VECTOR, .CTX_RESTORE, .GLOBAL_IRQ_DISABLE, .DEBUG_EVENT_MASK, .EMU_REG_WRITE_PERMIT);

// file: testbench/mia_accept_test.sv
// Self-checking bench for the interrupt acceptance block
`timescale 1ns/1ps
`include "mia_map.svh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin failures++; $display("mismatch %s exp %h got %h", n, e, s); end end
module mia_accept_test;
  logic CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, RT_EMU_HALT = 0, ret_go = 0, RETI, DECODE_EMPTY;
  logic PREADY, PSLVERR, FETCH_HOLD, FLUSH_YOUNGER, REDIRECT, CTX_RESTORE, IRQ;
  logic GLOBAL_IRQ_DISABLE, DEBUG_EVENT_MASK, EMU_REG_WRITE_PERMIT;
  logic [7:0] PADDR = 0;
  logic [31:0] PWDATA = 0, IRQ_REQ = 0, PRDATA;
  logic [15:0] CPU_STATUS = 0, RESTORE_STATUS, sv;
  logic [3:0] drain = 0;
  logic [4:0] REDIRECT_VECTOR;
  logic [32:0] q[$], ex;
  int failures = 0, n_compared = 0, seed = 32'h1157;
  mia_accept mia_accept_inst (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PRDATA, .PSLVERR,
    .IRQ_REQ, .RT_EMU_HALT, .DECODE_EMPTY, .RETI, .CPU_STATUS, .FETCH_HOLD, .FLUSH_YOUNGER, .REDIRECT,
    .REDIRECT_VECTOR, .CTX_RESTORE, .RESTORE_STATUS, .GLOBAL_IRQ_DISABLE, .DEBUG_EVENT_MASK,
    .EMU_REG_WRITE_PERMIT, .IRQ);
  mia_cpu_model mia_cpu_model_inst (.CLK, .RSTN, .FLUSH_YOUNGER, .drain, .ret_go, .DECODE_EMPTY, .RETI);
  initial forever #12.5 CLK = ~CLK;
  // Each read or redirect retires the oldest note
  always @(posedge CLK) begin
    if (REDIRECT === 1'b1 || (PREADY && PSEL && PENABLE && !PWRITE) === 1'b1) begin
      ex = q.size() ? q.pop_front() : 33'h1_FFFF_FFFF;
      `CHK("result", ex, REDIRECT ? {28'h0, REDIRECT_VECTOR} : {PSLVERR, PRDATA})
    end
  end
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  task automatic tmo;
    failures++;
    final_report();
  endtask : tmo
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    for (i = 0; i < 20 && PREADY !== 1'b1; i++) @(posedge CLK);
    if (i == 20) tmo();
    PSEL <= 0;
    PENABLE <= 0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(0, a, 0);
  endtask : rd
  task automatic waitq;
    int i;
    for (i = 0; i < 60 && q.size() != 0; i++) @(posedge CLK);
    if (i == 60) tmo();
  endtask : waitq
  task automatic req(input logic [31:0] m);
    @(posedge CLK);
    IRQ_REQ <= m;
    @(posedge CLK);
    IRQ_REQ <= 0;
    repeat (8) @(posedge CLK);
  endtask : req
  task automatic ret;
    @(posedge CLK);
    ret_go <= 1;
    @(posedge CLK);
    ret_go <= 0;
  endtask : ret
  initial begin
    repeat (20) @(posedge CLK);
    RSTN <= 1;
    repeat (3) @(posedge CLK);
    rd(`MIA_OFS_MODE, 33'h3);
    rd(8'hFC, 33'h1_0000_0000);
    $display("test 1 done");
    apb(1, `MIA_OFS_ENABLE_A, 32'h20);
    req(32'h20);
    rd(`MIA_OFS_FLAG_A, 33'h20);
    sv = 16'($random(seed));
    CPU_STATUS <= sv;
    apb(1, `MIA_OFS_EVT_MASK, 32'h1);
    q.push_back(33'h5);
    // Permit set and debug mask clear so entry visibly forces both
    apb(1, `MIA_OFS_MODE, 32'h4);
    waitq();
    repeat (2) @(posedge CLK);
    `CHK("irq", 1'b1, IRQ)
    `CHK("entry", 3'b110, {GLOBAL_IRQ_DISABLE, DEBUG_EVENT_MASK, EMU_REG_WRITE_PERMIT})
    rd(`MIA_OFS_FLAG_A, 33'h0);
    rd(`MIA_OFS_EVT_STAT, 33'h1);
    repeat (2) @(posedge CLK);
    `CHK("irq", 1'b0, IRQ)
    $display("test 2 done");
    apb(1, `MIA_OFS_ENABLE_A, 32'h8);
    apb(1, `MIA_OFS_ENABLE_B, 32'h100);
    CPU_STATUS <= 16'($random(seed));
    req(32'h0100_0008);
    q.push_back(33'h18);
    ret();
    waitq();
    `CHK("restore", sv, RESTORE_STATUS)
    rd(`MIA_OFS_FLAG_A, 33'h8);
    q.push_back(33'h3);
    ret();
    waitq();
    ret();
    rd(`MIA_OFS_MODE, 33'h4);
    $display("test 3 done");
    req(32'h80);
    rd(`MIA_OFS_FLAG_A, 33'h80);
    apb(1, `MIA_OFS_FLAG_A, 32'h80);
    rd(`MIA_OFS_FLAG_A, 33'h0);
    $display("test 4 done");
    apb(1, `MIA_OFS_MODE, 32'h1);
    RT_EMU_HALT <= 1;
    drain <= 4'h6;
    apb(1, `MIA_OFS_ENABLE_A, 32'h200);
    apb(1, `MIA_OFS_EVT_MASK, 32'h0);
    req(32'h200);
    rd(`MIA_OFS_FLAG_A, 33'h200);
    q.push_back(33'h9);
    apb(1, `MIA_OFS_CRIT_A, 32'h200);
    waitq();
    repeat (2) @(posedge CLK);
    `CHK("irq masked", 1'b0, IRQ)
    ret();
    // Flag withdrawn during a long drain: no branch, hold released
    drain <= 4'hF;
    req(32'h200);
    apb(1, `MIA_OFS_FLAG_A, 32'h200);
    repeat (10) @(posedge CLK);
    `CHK("hold", 1'b0, FETCH_HOLD)
    rd(`MIA_OFS_FLAG_A, 33'h0);
    $display("test 5 done");
    final_report();
  end
endmodule : mia_accept_test

// file: testbench/mia_cpu_model.sv
// Pipeline model: decode drain and return pulses
`timescale 1ns/1ps
module mia_cpu_model (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic FLUSH_YOUNGER,
  input wire logic [3:0] drain,
  input wire logic ret_go,
  output logic DECODE_EMPTY,
  output logic RETI
);
  logic [3:0] cnt;
  // Older instructions still finishing
  assign DECODE_EMPTY = !FLUSH_YOUNGER && cnt == 4'h0;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt <= 4'h0;
      RETI <= 1'b0;
    end else begin
      cnt <= FLUSH_YOUNGER ? drain : cnt - {3'h0, cnt != 4'h0};
      RETI <= ret_go;
    end
  end
endmodule : mia_cpu_model
